/* File: hdl/asw_dev.sv */
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module asw_dev
	import asw_pkg::*;
#(
	parameter int unsigned WAIT_STEP_CYCLES = ASW_WAIT_STEP_CYC
) (
	input wire logic clk,
	input wire logic rst,
	asw_i2c_if.dev bus,
	input wire logic [7:0] evt1,
	input wire logic [4:0] evt2,
	input wire logic [7:0] key_hit1,
	input wire logic [7:0] key_hit2,
	input wire logic [4:0] adc_code,
	input wire logic [7:0] acc_class1,
	input wire logic [7:0] acc_class2,
	input wire logic [7:0] auto_sw1,
	input wire logic [7:0] auto_sw2,
	input wire logic acc_is_jig,
	input wire logic [7:0] det_state,
	output logic irq_out_n,
	output logic [7:0] sw_state1,
	output logic [7:0] sw_state2,
	output logic adc_run,
	output logic key_mon_run,
	output logic [7:0] ext_ctrl,
	output logic [7:0] idle_delay,
	output logic [7:0] mode_sel,
	output logic [7:0] wake_key_timing,
	output logic [3:0] longkey_timing
);
	typedef struct packed {
		logic [2:0] scl_sy, sda_sy;
		logic scl_f, sda_f;
		asw_slv_e st;
		logic [3:0] bitc;
		logic [7:0] sh, ptr;
		logic rw, ptr_phase, sda_low, nack;
		asw_regs_s r;
		logic sw_ready, timing;
		logic [3:0] wsteps;
		logic [23:0] presc;
		logic irq_n;
		logic [7:0] sw1, sw2;
	} asw_dev_s;

	asw_dev_s s, n;
	logic scl_r, scl_fl, sta, sto, do_rd, do_wr, raw, allow;
	logic [7:0] rd_data, set1, set2;

	function automatic logic [7:0] rd_mux(input asw_regs_s r, input logic [7:0] a, input logic [7:0] c1,
		input logic [7:0] c2, input logic [7:0] ds);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			ASW_OFF_ID: v = {ASW_REV_CODE, ASW_MAKER_CODE};
			ASW_OFF_CTRL: v = r.ctrl;
			ASW_OFF_FLG1: v = r.flg1;
			ASW_OFF_FLG2: v = r.flg2;
			ASW_OFF_MSK1: v = r.msk1;
			ASW_OFF_MSK2: v = r.msk2;
			ASW_OFF_ADC: v = r.adcv;
			ASW_OFF_TIM1: v = r.tim1;
			ASW_OFF_TIM2: v = r.tim2;
			ASW_OFF_CLS1: v = c1;
			ASW_OFF_CLS2: v = c2;
			ASW_OFF_KEY1: v = r.key1;
			ASW_OFF_KEY2: v = r.key2;
			ASW_OFF_MAN1: v = r.man1;
			ASW_OFF_MAN2: v = r.man2;
			ASW_OFF_DET: v = ds;
			ASW_OFF_EXT: v = r.ext;
			ASW_OFF_IDLE: v = r.idle;
			ASW_OFF_MODE: v = r.mode;
			default: v = 8'h00;
		endcase
		return v;
	endfunction : rd_mux

	always_comb begin
		n = s;
		do_rd = 1'b0;
		do_wr = 1'b0;
		n.scl_sy = {s.scl_sy[1:0], bus.scl};
		n.sda_sy = {s.sda_sy[1:0], bus.sda};
		if (s.scl_sy[1] == s.scl_sy[2]) begin
			n.scl_f = s.scl_sy[2];
		end
		if (s.sda_sy[1] == s.sda_sy[2]) begin
			n.sda_f = s.sda_sy[2];
		end
		scl_r = n.scl_f & ~s.scl_f;
		scl_fl = ~n.scl_f & s.scl_f;
		sta = s.scl_f & n.scl_f & s.sda_f & ~n.sda_f;
		sto = s.scl_f & n.scl_f & ~s.sda_f & n.sda_f;
		rd_data = rd_mux(s.r, s.ptr, acc_class1, acc_class2, det_state);
		// The link logic never looks at the power mode, so it answers in all of them
		if (sta) begin
			n.st = ASW_I_ADDR;
			n.bitc = 4'h0;
			n.ptr_phase = 1'b1;
			n.sda_low = 1'b0;
		end else if (sto) begin
			n.st = ASW_I_IDLE;
			n.sda_low = 1'b0;
		end else if (scl_r) begin
			case (s.st)
				ASW_I_ADDR, ASW_I_WR: begin
					n.sh = {s.sh[6:0], n.sda_f};
					n.bitc = s.bitc + 4'h1;
				end
				ASW_I_RD: n.bitc = s.bitc + 4'h1;
				ASW_I_RACK: n.nack = n.sda_f;
				default: ;
			endcase
		end else if (scl_fl) begin
			case (s.st)
				ASW_I_ADDR: begin
					if (s.bitc == 4'h8) begin
						if (s.sh[7:1] == ASW_SLAVE_ADDR) begin
							n.st = ASW_I_ACKA;
							n.sda_low = 1'b1;
							n.rw = s.sh[0];
						end else begin
							n.st = ASW_I_IDLE;
						end
					end
				end
				ASW_I_ACKA: begin
					n.bitc = 4'h0;
					if (s.rw) begin
						do_rd = 1'b1;
					end else begin
						n.sda_low = 1'b0;
						n.st = ASW_I_WR;
					end
				end
				ASW_I_WR: begin
					if (s.bitc == 4'h8) begin
						n.sda_low = 1'b1;
						n.st = ASW_I_ACKW;
						do_wr = 1'b1;
					end
				end
				ASW_I_ACKW: begin
					n.sda_low = 1'b0;
					n.st = ASW_I_WR;
					n.bitc = 4'h0;
				end
				ASW_I_RD: begin
					if (s.bitc == 4'h8) begin
						n.sda_low = 1'b0;
						n.st = ASW_I_RACK;
					end else begin
						n.sh = {s.sh[6:0], 1'b0};
						n.sda_low = ~s.sh[6];
					end
				end
				ASW_I_RACK: begin
					if (s.nack) begin
						n.st = ASW_I_IDLE;
					end else begin
						do_rd = 1'b1;
					end
				end
				default: n.st = ASW_I_IDLE;
			endcase
		end
		if (do_rd) begin
			n.sh = rd_data;
			n.sda_low = ~rd_data[7];
			n.st = ASW_I_RD;
			n.bitc = 4'h0;
			n.ptr = s.ptr + 8'h01;
			case (s.ptr)
				ASW_OFF_FLG1: n.r.flg1 = 8'h00;
				ASW_OFF_FLG2: n.r.flg2 = 8'h00;
				ASW_OFF_KEY1: n.r.key1 = 8'h00;
				ASW_OFF_KEY2: n.r.key2 = 8'h00;
				default: ;
			endcase
		end
		if (do_wr) begin
			if (s.ptr_phase) begin
				n.ptr = s.sh;
				n.ptr_phase = 1'b0;
			end else begin
				n.ptr = s.ptr + 8'h01;
				case (s.ptr)
					ASW_OFF_CTRL: n.r.ctrl = s.sh & ASW_CTRL_WMASK;
					ASW_OFF_MSK1: n.r.msk1 = s.sh;
					ASW_OFF_MSK2: n.r.msk2 = s.sh & ASW_MSK2_WMASK;
					ASW_OFF_TIM1: n.r.tim1 = s.sh;
					ASW_OFF_TIM2: n.r.tim2 = s.sh;
					ASW_OFF_MAN1: n.r.man1 = s.sh;
					ASW_OFF_MAN2: n.r.man2 = s.sh & ASW_MAN2_WMASK;
					ASW_OFF_EXT: n.r.ext = s.sh & ASW_EXT_WMASK;
					ASW_OFF_IDLE: n.r.idle = s.sh;
					ASW_OFF_MODE: n.r.mode = s.sh & ASW_MODE_WMASK;
					default: ;
				endcase
			end
		end
		raw = s.r.ctrl[ASW_CB_RAW];
		// Conversion tracking and key reporting are exclusive, picked by the report bit
		set1 = evt1 & (raw ? 8'hFF : ~ASW_KEY_EVT1);
		set2 = {3'h0, evt2 & (raw ? 5'h1F : ~ASW_KEY_EVT2)};
		if (!raw) begin
			n.r.adcv = {3'h0, adc_code};
			if (adc_code != s.r.adcv[4:0]) begin
				set2[ASW_ADC_CHG_BIT] = 1'b1;
			end
		end else begin
			n.r.key1 = n.r.key1 | key_hit1;
			n.r.key2 = n.r.key2 | (key_hit2 & 8'h7F);
		end
		// Setting after the read-clear means an event in the clearing cycle survives
		n.r.flg1 = n.r.flg1 | set1;
		n.r.flg2 = n.r.flg2 | set2;
		if (s.timing) begin
			if (s.presc == 24'(WAIT_STEP_CYCLES - 1)) begin
				n.presc = 24'h000000;
				if (s.wsteps == 4'h0) begin
					n.sw_ready = 1'b1;
					n.timing = 1'b0;
				end else begin
					n.wsteps = s.wsteps - 4'h1;
				end
			end else begin
				n.presc = s.presc + 24'h000001;
			end
		end
		if (evt1[0]) begin
			n.sw_ready = 1'b0;
			n.timing = s.r.ctrl[ASW_CB_WAIT];
			n.wsteps = s.r.tim2[7:ASW_TIM2_WAIT_LSB];
			n.presc = 24'h000000;
		end
		if (evt1[1]) begin
			n.sw_ready = 1'b0;
			n.timing = 1'b0;
		end
		if (!s.r.ctrl[ASW_CB_WAIT] && n.r.ctrl[ASW_CB_WAIT]) begin
			n.sw_ready = 1'b1;
			n.timing = 1'b0;
		end
		if (do_wr && !s.ptr_phase && s.ptr == ASW_OFF_EXT && s.sh[ASW_EB_SRST]) begin
			n.r = ASW_REGS_RST;
			n.sw_ready = 1'b0;
			n.timing = 1'b0;
		end
		n.irq_n = n.r.ctrl[ASW_CB_MASK] ? 1'b0 :
			~|((n.r.flg1 & ~n.r.msk1) | (n.r.flg2 & ~n.r.msk2));
		// Mask set keeps only the jig cable switched; otherwise the defer logic gates
		allow = n.r.ctrl[ASW_CB_MASK] ? acc_is_jig : n.sw_ready;
		if (!n.r.ctrl[ASW_CB_OPEN] || !allow) begin
			n.sw1 = 8'h00;
			n.sw2 = 8'h00;
		end else if (n.r.ctrl[ASW_CB_SRC]) begin
			n.sw1 = auto_sw1;
			n.sw2 = auto_sw2;
		end else begin
			n.sw1 = n.r.man1;
			n.sw2 = n.r.man2;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
			s.scl_sy <= 3'h7;
			s.sda_sy <= 3'h7;
			s.scl_f <= 1'b1;
			s.sda_f <= 1'b1;
			s.r <= ASW_REGS_RST;
		end else begin
			s <= n;
		end
	end

	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe_n = ~s.sda_low;
	assign irq_out_n = s.irq_n;
	assign sw_state1 = s.sw1;
	assign sw_state2 = s.sw2;
	assign adc_run = ~s.r.ctrl[ASW_CB_RAW];
	assign key_mon_run = s.r.ctrl[ASW_CB_RAW];
	assign ext_ctrl = s.r.ext;
	assign idle_delay = s.r.idle;
	assign mode_sel = s.r.mode;
	assign wake_key_timing = s.r.tim1;
	assign longkey_timing = s.r.tim2[3:0];
endmodule : asw_dev
`default_nettype wire

/* File: hdl/asw_pkg.sv */
package asw_pkg;
	localparam logic [6:0] ASW_SLAVE_ADDR = 7'h25;
	localparam int ASW_CLK_MHZ = 250;
	localparam int ASW_MAX_KBPS = 400;
	// Quarter of the shortest legal bit period, rounded up so the rate never exceeds the limit
	localparam int ASW_QTR_CYC = (ASW_CLK_MHZ * 1000 + 4 * ASW_MAX_KBPS - 1) / (4 * ASW_MAX_KBPS);
	localparam int ASW_WAIT_STEP_US = 100;
	localparam int ASW_WAIT_STEP_CYC = ASW_WAIT_STEP_US * ASW_CLK_MHZ;
	// Identity fields: arbitrary values
	localparam logic [2:0] ASW_MAKER_CODE = 3'h5;
	localparam logic [4:0] ASW_REV_CODE = 5'h03;

	localparam logic [7:0] ASW_OFF_ID = 8'h01;
	localparam logic [7:0] ASW_OFF_CTRL = 8'h02;
	localparam logic [7:0] ASW_OFF_FLG1 = 8'h03;
	localparam logic [7:0] ASW_OFF_FLG2 = 8'h04;
	localparam logic [7:0] ASW_OFF_MSK1 = 8'h05;
	localparam logic [7:0] ASW_OFF_MSK2 = 8'h06;
	localparam logic [7:0] ASW_OFF_ADC = 8'h07;
	localparam logic [7:0] ASW_OFF_TIM1 = 8'h08;
	localparam logic [7:0] ASW_OFF_TIM2 = 8'h09;
	localparam logic [7:0] ASW_OFF_CLS1 = 8'h0A;
	localparam logic [7:0] ASW_OFF_CLS2 = 8'h0B;
	localparam logic [7:0] ASW_OFF_KEY1 = 8'h0C;
	localparam logic [7:0] ASW_OFF_KEY2 = 8'h0D;
	localparam logic [7:0] ASW_OFF_MAN1 = 8'h13;
	localparam logic [7:0] ASW_OFF_MAN2 = 8'h14;
	localparam logic [7:0] ASW_OFF_DET = 8'h20;
	localparam logic [7:0] ASW_OFF_EXT = 8'h21;
	localparam logic [7:0] ASW_OFF_IDLE = 8'h22;
	localparam logic [7:0] ASW_OFF_MODE = 8'h23;

	localparam int ASW_CB_MASK = 0;
	localparam int ASW_CB_WAIT = 1;
	localparam int ASW_CB_SRC = 2;
	localparam int ASW_CB_RAW = 3;
	localparam int ASW_CB_OPEN = 4;
	localparam int ASW_EB_SRST = 2;
	localparam int ASW_TIM2_WAIT_LSB = 4;

	localparam logic [7:0] ASW_CTRL_WMASK = 8'h1F;
	localparam logic [7:0] ASW_MSK2_WMASK = 8'h1F;
	localparam logic [7:0] ASW_MAN2_WMASK = 8'h1C;
	localparam logic [7:0] ASW_EXT_WMASK = 8'hE2;
	localparam logic [7:0] ASW_MODE_WMASK = 8'h07;
	localparam logic [7:0] ASW_KEY_EVT1 = 8'h1C;
	localparam logic [4:0] ASW_KEY_EVT2 = 5'h18;
	localparam int ASW_ADC_CHG_BIT = 2;

	typedef struct packed {
		logic [7:0] ctrl, flg1, flg2, msk1, msk2, adcv, tim1, tim2;
		logic [7:0] key1, key2, man1, man2, ext, idle, mode;
	} asw_regs_s;

	localparam asw_regs_s ASW_REGS_RST = '{ctrl: 8'h1F, flg1: 8'h00, flg2: 8'h00, msk1: 8'h00,
		msk2: 8'h00, adcv: 8'h1F, tim1: 8'h00, tim2: 8'h00, key1: 8'h00, key2: 8'h00,
		man1: 8'h00, man2: 8'h00, ext: 8'h20, idle: 8'h94, mode: 8'h01};

	typedef enum logic [2:0] {ASW_I_IDLE, ASW_I_ADDR, ASW_I_ACKA, ASW_I_WR, ASW_I_ACKW, ASW_I_RD,
		ASW_I_RACK} asw_slv_e;
	typedef enum logic [1:0] {ASW_M_IDLE, ASW_M_START, ASW_M_BIT, ASW_M_STOP} asw_mst_e;

	localparam logic [1:0] ASW_OP_START = 2'h0;
	localparam logic [1:0] ASW_OP_TX = 2'h1;
	localparam logic [1:0] ASW_OP_RX = 2'h2;
	localparam logic [1:0] ASW_OP_STOP = 2'h3;
	localparam logic [1:0] ASW_K_WR = 2'h0;
	localparam logic [1:0] ASW_K_PRD = 2'h1;
	localparam logic [1:0] ASW_K_IRD = 2'h2;

	localparam logic [2:0] ASW_H_PTR = 3'h0;
	localparam logic [2:0] ASW_H_DATA = 3'h1;
	localparam logic [2:0] ASW_H_CMD = 3'h2;
	localparam logic [2:0] ASW_H_STAT = 3'h3;
	localparam logic [2:0] ASW_H_RX = 3'h4;
endpackage : asw_pkg

/* File: hdl/asw_i2c_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface asw_i2c_if;
	logic host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n;
	logic dev_sda_o, dev_sda_oe_n;
	wire scl;
	wire sda;
	// Open-drain lines with pull-ups: a line is low only where a party enables a low drive
	assign scl = (!host_scl_oe_n && !host_scl_o) ? 1'b0 : 1'b1;
	assign sda = ((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o)) ? 1'b0 : 1'b1;
	modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
	modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n, output host_sda_o,
		output host_sda_oe_n);
endinterface : asw_i2c_if
`default_nettype wire

/* File: hdl/asw_host.sv */
`timescale 1ns/1ps
`default_nettype none
module asw_host
	import asw_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	asw_i2c_if.host bus,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata
);
	typedef struct packed {
		logic [2:0] sda_sy;
		logic sda_f;
		asw_mst_e st;
		logic [1:0] q;
		logic [7:0] qcnt;
		logic [2:0] step;
		logic [1:0] kind;
		logic [1:0] op;
		logic [3:0] bitc;
		logic [7:0] sh, rx, ptr, dat, rdata;
		logic nack, busy, scl_low, sda_low;
	} asw_host_s;

	asw_host_s s, n;

	function automatic logic [9:0] seq(input logic [1:0] k, input logic [2:0] st, input logic [7:0] p,
		input logic [7:0] d);
		logic [9:0] r;
		r = {ASW_OP_STOP, 8'h00};
		case (k)
			ASW_K_WR: begin
				case (st)
					3'h0: r = {ASW_OP_START, 8'h00};
					3'h1: r = {ASW_OP_TX, ASW_SLAVE_ADDR, 1'b0};
					3'h2: r = {ASW_OP_TX, p};
					3'h3: r = {ASW_OP_TX, d};
					default: r = {ASW_OP_STOP, 8'h00};
				endcase
			end
			ASW_K_PRD: begin
				case (st)
					3'h0: r = {ASW_OP_START, 8'h00};
					3'h1: r = {ASW_OP_TX, ASW_SLAVE_ADDR, 1'b0};
					3'h2: r = {ASW_OP_TX, p};
					3'h3: r = {ASW_OP_START, 8'h00};
					3'h4: r = {ASW_OP_TX, ASW_SLAVE_ADDR, 1'b1};
					3'h5: r = {ASW_OP_RX, 8'h00};
					default: r = {ASW_OP_STOP, 8'h00};
				endcase
			end
			ASW_K_IRD: begin
				case (st)
					3'h0: r = {ASW_OP_START, 8'h00};
					3'h1: r = {ASW_OP_TX, ASW_SLAVE_ADDR, 1'b1};
					3'h2: r = {ASW_OP_RX, 8'h00};
					default: r = {ASW_OP_STOP, 8'h00};
				endcase
			end
			default: r = {ASW_OP_STOP, 8'h00};
		endcase
		return r;
	endfunction : seq

	logic tick;
	logic [9:0] nxt_op;

	always_comb begin
		n = s;
		n.sda_sy = {s.sda_sy[1:0], bus.sda};
		if (s.sda_sy[1] == s.sda_sy[2]) begin
			n.sda_f = s.sda_sy[2];
		end
		tick = (s.qcnt == 8'(ASW_QTR_CYC - 1));
		nxt_op = seq(s.kind, s.step + 3'h1, s.ptr, s.dat);
		if (s.st != ASW_M_IDLE) begin
			n.qcnt = tick ? 8'h00 : s.qcnt + 8'h01;
		end
		if (wr) begin
			case (addr)
				ASW_H_PTR: n.ptr = wdata;
				ASW_H_DATA: n.dat = wdata;
				ASW_H_CMD: begin
					if (!s.busy && wdata[1:0] != 2'h3) begin
						n.kind = wdata[1:0];
						n.step = 3'h0;
						n.busy = 1'b1;
						n.nack = 1'b0;
						n.st = ASW_M_START;
						n.q = 2'h0;
						n.qcnt = 8'h00;
					end
				end
				default: ;
			endcase
		end
		if (tick) begin
			n.q = s.q + 2'h1;
			case (s.st)
				ASW_M_START: begin
					case (s.q)
						2'h0: n.sda_low = 1'b0;
						2'h1: n.scl_low = 1'b0;
						2'h2: n.sda_low = 1'b1;
						default: n.scl_low = 1'b1;
					endcase
				end
				ASW_M_BIT: begin
					case (s.q)
						2'h0: n.sda_low = (s.op == ASW_OP_TX && s.bitc < 4'h8) ? ~s.sh[7] : 1'b0;
						2'h1: n.scl_low = 1'b0;
						2'h2: begin
							if (s.bitc < 4'h8) begin
								n.sh = {s.sh[6:0], s.sda_f};
							end else if (s.op == ASW_OP_TX) begin
								n.nack = s.sda_f;
							end
						end
						default: begin
							n.scl_low = 1'b1;
							n.bitc = s.bitc + 4'h1;
						end
					endcase
				end
				ASW_M_STOP: begin
					case (s.q)
						2'h0: n.sda_low = 1'b1;
						2'h1: n.scl_low = 1'b0;
						2'h2: n.sda_low = 1'b0;
						default: begin
							n.busy = 1'b0;
							n.st = ASW_M_IDLE;
						end
					endcase
				end
				default: ;
			endcase
			if (s.q == 2'h3 && (s.st == ASW_M_START || (s.st == ASW_M_BIT && s.bitc == 4'h8))) begin
				if (s.st == ASW_M_BIT && s.op == ASW_OP_RX) begin
					n.rx = s.sh;
				end
				n.step = s.step + 3'h1;
				n.op = nxt_op[9:8];
				n.sh = nxt_op[7:0];
				n.bitc = 4'h0;
				if (n.nack || nxt_op[9:8] == ASW_OP_STOP) begin
					n.st = ASW_M_STOP;
				end else if (nxt_op[9:8] == ASW_OP_START) begin
					n.st = ASW_M_START;
				end else begin
					n.st = ASW_M_BIT;
				end
			end
		end
		if (rd) begin
			case (addr)
				ASW_H_PTR: n.rdata = s.ptr;
				ASW_H_DATA: n.rdata = s.dat;
				ASW_H_STAT: n.rdata = {6'h00, s.nack, s.busy};
				ASW_H_RX: n.rdata = s.rx;
				default: n.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
			s.sda_sy <= 3'h7;
			s.sda_f <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign rdata = s.rdata;
	assign bus.host_scl_o = 1'b0;
	assign bus.host_scl_oe_n = ~s.scl_low;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_sda_oe_n = ~s.sda_low;
endmodule : asw_host
`default_nettype wire

/* File: bench/asw_bus_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module asw_bus_monitor
	import asw_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_oe_n
);
	default clocking mon_cb @(posedge clk);
	endclocking
	default disable iff (rst);

	logic [3:0] bitc_ff;
	logic [7:0] sh_ff;
	logic in_addr_ff;
	logic matched_ff;
	logic rw_ff;
	logic [9:0] since_ff;

	// Frame tracker rebuilt from the wires alone, so it cannot share a fault with either end
	always_ff @(posedge clk) begin
		if (rst) begin
			bitc_ff <= 4'h0;
			sh_ff <= 8'h00;
			in_addr_ff <= 1'b0;
			matched_ff <= 1'b0;
			rw_ff <= 1'b0;
			since_ff <= 10'h3FF;
		end else begin
			since_ff <= $rose(scl) ? 10'h000 : ((since_ff == 10'h3FF) ? since_ff : since_ff + 10'h001);
			if (scl && $past(scl) && $fell(sda)) begin
				bitc_ff <= 4'h0;
				in_addr_ff <= 1'b1;
				matched_ff <= 1'b0;
			end else if (scl && $past(scl) && $rose(sda)) begin
				in_addr_ff <= 1'b0;
				matched_ff <= 1'b0;
			end else if ($rose(scl)) begin
				if (bitc_ff == 4'h8) begin
					bitc_ff <= 4'h0;
					in_addr_ff <= 1'b0;
					if (in_addr_ff) begin
						matched_ff <= (sh_ff[7:1] == ASW_SLAVE_ADDR);
						rw_ff <= sh_ff[0];
					end
				end else begin
					bitc_ff <= bitc_ff + 4'h1;
					sh_ff <= {sh_ff[6:0], sda};
				end
			end
		end
	end

	sequence ack_slot;
		$rose(scl) && bitc_ff == 4'h8;
	endsequence
	// Bit 0 is left out: a stop condition starts with a rise that looks like it
	sequence data_slot;
		$rose(scl) && bitc_ff != 4'h0 && bitc_ff != 4'h8;
	endsequence

	addr_ack_a: assert property (ack_slot ##0 (in_addr_ff && sh_ff[7:1] == ASW_SLAVE_ADDR) |-> !sda)
		else $error("own address not acknowledged");
	addr_quiet_a: assert property (in_addr_ff && bitc_ff != 4'h8 |-> dev_sda_oe_n)
		else $error("device drove data during the address byte");
	wr_ack_a: assert property (ack_slot ##0 (!in_addr_ff && matched_ff && !rw_ff) |-> !sda)
		else $error("written byte not acknowledged");
	rd_nack_a: assert property (ack_slot ##0 (!in_addr_ff && matched_ff && rw_ff) |-> sda && dev_sda_oe_n)
		else $error("read byte acknowledge slot not released");
	host_quiet_a: assert property (data_slot ##0 (matched_ff && rw_ff) |-> host_sda_oe_n)
		else $error("master drove data during a read");
	idle_release_a: assert property (!matched_ff && !in_addr_ff |-> dev_sda_oe_n)
		else $error("device drove data while not addressed");
	scl_rate_a: assert property ($rose(scl) |-> since_ff >= 10'h270)
		else $error("serial clock faster than the bus limit");
	dev_edge_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
		else $error("device changed data while the clock was high");
endmodule : asw_bus_monitor
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
	import asw_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] h_addr = 3'h0;
	logic [7:0] h_wdata = 8'h00;
	logic h_wr = 1'b0;
	logic h_rd = 1'b0;
	logic [7:0] h_rdata;
	logic [7:0] evt1 = 8'h00;
	logic [4:0] evt2 = 5'h00;
	logic acc_is_jig = 1'b0;
	logic [4:0] adc_code = 5'h1F;
	logic [7:0] acc_class1 = 8'h00;
	logic [7:0] acc_class2 = 8'h00;
	logic [7:0] auto_sw1 = 8'h00;
	logic [7:0] auto_sw2 = 8'h00;
	logic irq_out_n, adc_run, key_mon_run;
	logic [7:0] sw_state1, sw_state2, ext_ctrl, idle_delay, mode_sel;
	int fails = 0;
	int comparisons = 0;

	always #2 clk = ~clk;

	asw_i2c_if bus_if();
	asw_host asw_host_inst (.clk(clk), .rst(rst), .bus(bus_if), .addr(h_addr), .wdata(h_wdata), .wr(h_wr),
		.rd(h_rd), .rdata(h_rdata));
	// A short wait step keeps the switching delay within a few cycles
	asw_dev #(.WAIT_STEP_CYCLES(4)) asw_dev_inst (.clk(clk), .rst(rst), .bus(bus_if), .evt1(evt1),
		.evt2(evt2), .key_hit1(8'h00), .key_hit2(8'h00), .adc_code(adc_code), .acc_class1(acc_class1),
		.acc_class2(acc_class2), .auto_sw1(auto_sw1), .auto_sw2(auto_sw2), .acc_is_jig(acc_is_jig),
		.det_state(8'h00), .irq_out_n(irq_out_n), .sw_state1(sw_state1), .sw_state2(sw_state2),
		.adc_run(adc_run), .key_mon_run(key_mon_run), .ext_ctrl(ext_ctrl), .idle_delay(idle_delay),
		.mode_sel(mode_sel), .wake_key_timing(), .longkey_timing());
	asw_bus_monitor asw_bus_monitor_inst (.clk(clk), .rst(rst), .scl(bus_if.scl), .sda(bus_if.sda),
		.host_sda_oe_n(bus_if.host_sda_oe_n), .dev_sda_oe_n(bus_if.dev_sda_oe_n));

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wait_cyc

	task automatic hwr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		h_addr <= a;
		h_wdata <= d;
		h_wr <= 1'b1;
		@(posedge clk);
		h_wr <= 1'b0;
	endtask : hwr

	task automatic hrd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		h_addr <= a;
		h_rd <= 1'b1;
		@(posedge clk);
		h_rd <= 1'b0;
		#1;
		d = h_rdata;
	endtask : hrd

	// Busy is polled under a bound; a hang shows up as busy still set
	task automatic run_cmd(input logic [7:0] ptr, input logic [7:0] dat, input logic [1:0] kind);
		logic [7:0] s;
		int n;
		hwr(3'h0, ptr);
		hwr(3'h1, dat);
		hwr(3'h2, {6'h00, kind});
		n = 0;
		s = 8'h01;
		while (s[0] !== 1'b0 && n < 20000) begin
			hrd(3'h3, s);
			n++;
		end
		check({6'h00, s[1:0]}, 8'h00, "transfer acknowledged and done");
	endtask : run_cmd

	task automatic rd_byte(input logic [1:0] kind, input logic [7:0] ptr, output logic [7:0] d);
		run_cmd(ptr, 8'h00, kind);
		hrd(3'h4, d);
	endtask : rd_byte

	task automatic t_reset();
		logic [7:0] d;
		check({7'h00, irq_out_n}, 8'h00, "irq held low while masked");
		check({6'h00, key_mon_run, adc_run}, 8'h02, "report mode after reset");
		check(ext_ctrl, 8'h20, "extended control reset");
		check(idle_delay, 8'h94, "idle delay reset");
		check(mode_sel, 8'h01, "mode reset");
		check(sw_state1, 8'h00, "switches off after reset");
		hrd(3'h7, d);
		check(d, 8'h00, "unmapped host register");
		$display("test reset done");
	endtask : t_reset

	task automatic t_reads();
		logic [7:0] d;
		rd_byte(ASW_K_PRD, ASW_OFF_ID, d);
		check(d, {ASW_REV_CODE, ASW_MAKER_CODE}, "identity via pointer read");
		rd_byte(ASW_K_IRD, 8'h00, d);
		check(d, 8'h1F, "bare read after step");
		$display("test reads done");
	endtask : t_reads

	task automatic t_attach();
		logic [7:0] d;
		@(posedge clk);
		acc_class1 <= 8'h04;
		acc_class2 <= 8'h10;
		auto_sw1 <= 8'h24;
		auto_sw2 <= 8'h08;
		// Reserved top bits written as ones must be dropped
		run_cmd(ASW_OFF_CTRL, 8'hF6, ASW_K_WR);
		wait_cyc(10);
		check({7'h00, irq_out_n}, 8'h01, "irq idle when unmasked");
		check({6'h00, key_mon_run, adc_run}, 8'h01, "conversion reporting selected");
		@(posedge clk);
		evt1 <= 8'h01;
		@(posedge clk);
		evt1 <= 8'h00;
		wait_cyc(1);
		check(sw_state1, 8'h00, "switches wait for delay");
		wait_cyc(20);
		check(sw_state1, 8'h24, "auto switch map 1");
		check(sw_state2, 8'h08, "auto switch map 2");
		check({7'h00, irq_out_n}, 8'h00, "attach raises irq");
		rd_byte(ASW_K_IRD, 8'h00, d);
		check(d, 8'h01, "event flags at stepped pointer");
		wait_cyc(4);
		check({7'h00, irq_out_n}, 8'h01, "flags cleared by read");
		@(posedge clk);
		evt2 <= 5'h18;
		@(posedge clk);
		evt2 <= 5'h00;
		wait_cyc(4);
		check({7'h00, irq_out_n}, 8'h01, "key events ignored while converting");
		@(posedge clk);
		adc_code <= 5'h0A;
		wait_cyc(10);
		check({7'h00, irq_out_n}, 8'h00, "conversion change reported");
		$display("test attach done");
	endtask : t_attach

	task automatic t_soft_reset();
		run_cmd(ASW_OFF_EXT, 8'h24, ASW_K_WR);
		wait_cyc(10);
		check(ext_ctrl, 8'h20, "reset bit clears itself");
		check({7'h00, irq_out_n}, 8'h00, "mask restored");
		check(sw_state1, 8'h00, "switches off when masked");
		check({6'h00, key_mon_run, adc_run}, 8'h02, "control restored");
		@(posedge clk);
		acc_is_jig <= 1'b1;
		wait_cyc(4);
		check(sw_state1, 8'h24, "jig cable switched while masked");
		$display("test soft reset done");
	endtask : t_soft_reset

	task automatic end_sim();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim

	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		wait_cyc(8);
		t_reset();
		t_reads();
		t_attach();
		t_soft_reset();
		end_sim();
	end

	// The five transfers need about 86k cycles; the margin stays inside the run budget
	initial begin
		repeat (99000) @(posedge clk);
		fails++;
		end_sim();
	end
endmodule : testbench
`default_nettype wire
